// ### scm_map.svh
`ifndef SCM_MAP_SVH
`define SCM_MAP_SVH
`define SCM_ADDR_SCC     8'h00
`define SCM_ADDR_FOC     8'h01
`define SCM_ADDR_STAT    8'h02
`define SCM_SCC_RESET    8'h00
`define SCM_FOC_RESET    8'h01
`define SCM_SCC_SEL_HI   7
`define SCM_SCC_SEL_LO   5
`define SCM_SCC_FIDLE    1
`define SCM_SCC_SIDLE    0
`define SCM_FOC_FSEL_HI  3
`define SCM_FOC_FSEL_LO  2
`define SCM_FOC_STABLE   1
`define SCM_FOC_EN       0
`define SCM_SEL_SUB      3'h7
`define SCM_SETTLE_CYC   1024
`endif

// ### scm_pkg.sv
package scm_pkg;
    typedef enum logic [2:0] {
        MODE_FAST            = 3'b000,
        MODE_SLOW            = 3'b001,
        MODE_SLEEP           = 3'b010,
        MODE_IDLE_SUB_ONLY   = 3'b011,
        MODE_IDLE_ALL_ON     = 3'b100,
        MODE_IDLE_FAST_ONLY  = 3'b101
    } scm_mode_type;
    typedef enum logic [1:0] {
        FREQ_8M  = 2'b00,
        FREQ_12M = 2'b01,
        FREQ_16M = 2'b10
    } scm_freq_type;
    typedef enum logic [1:0] {
        SW_STEADY   = 2'b00,
        SW_WAIT_CUR = 2'b01,
        SW_WAIT_TAR = 2'b10
    } scm_sw_type;
endpackage

// ### scm_clk_div.sv
`timescale 1ns/1ps
// Ripple-free divider: each tap is a one-cycle tick on every 2^i-th fast tick
module scm_clk_div #(
    parameter int N_TAPS = 7
) (
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    input  wire logic              fast_tick,
    input  wire logic              fast_ok,
    output wire logic [N_TAPS-1:0] div_tick
);
    logic [N_TAPS-2:0] cnt_reg;

    if (N_TAPS < 2 || N_TAPS > 8) begin : g_chk
        $error("scm_clk_div: N_TAPS out of range");
    end

    // Counter clears while the oscillator is unusable, so taps restart aligned
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_reg <= '0;
        end else if (!fast_ok) begin
            cnt_reg <= '0;
        end else if (fast_tick) begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    assign div_tick[0] = fast_tick & fast_ok;
    for (genvar i = 1; i < N_TAPS; i++) begin : g_tap
        assign div_tick[i] = fast_tick & fast_ok & (&cnt_reg[i-1:0]);
    end
endmodule

// ### scm_clk_sel.sv
`timescale 1ns/1ps
// Glitch-free source selector working on tick pulses of each candidate
module scm_clk_sel
    import scm_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire logic [7:0] src_tick,
    input  wire logic [2:0] tgt_sel,
    input  wire logic       tgt_ready,
    output logic      [2:0] active_sel,
    output logic            switching,
    output wire logic       sys_tick
);
    scm_sw_type state_reg;
    scm_sw_type state_next;
    logic [2:0] pend_reg;
    logic [2:0] pend_next;
    logic [2:0] act_next;
    wire        cur_tick = src_tick[active_sel];
    wire        tar_tick = src_tick[pend_reg];

    // switch only at the end of a current period and the start of a target one
    always_comb begin
        state_next = state_reg;
        pend_next  = pend_reg;
        act_next   = active_sel;
        unique case (state_reg)
            SW_STEADY: begin
                if (tgt_sel != active_sel) begin
                    pend_next  = tgt_sel;
                    state_next = SW_WAIT_CUR;
                end
            end
            SW_WAIT_CUR: begin
                if (cur_tick) begin
                    state_next = SW_WAIT_TAR;
                end
            end
            SW_WAIT_TAR: begin
                // Held off until the target oscillator is usable
                if (tar_tick && tgt_ready) begin
                    act_next   = pend_reg;
                    state_next = SW_STEADY;
                end
            end
            default: state_next = SW_STEADY;
        endcase
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg  <= SW_STEADY;
            pend_reg   <= 3'h0;
            active_sel <= 3'h0;
        end else begin
            state_reg  <= state_next;
            pend_reg   <= pend_next;
            active_sel <= act_next;
        end
    end

    // Quiet gap between the last old tick and the first new one
    assign sys_tick  = cur_tick & (state_reg != SW_WAIT_TAR);
    assign switching = (state_reg != SW_STEADY);
endmodule

// ### scm_top.sv
`timescale 1ns/1ps
`include "scm_map.svh"
// System clock and operating-mode controller; oscillators appear as tick pulses
module scm_top
    import scm_pkg::*;
#(
    parameter int FAST_SETTLE_CYCLES = `SCM_SETTLE_CYC
) (
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       halt_req,
    input  wire logic       wake_req,
    input  wire logic       wdt_enable,
    input  wire logic       fast_rc_tick,
    input  wire logic       slow_rc_tick,
    output logic            fast_rc_run,
    output scm_freq_type    fast_rc_trim,
    output logic            slow_rc_run,
    output logic            sub_clk_run,
    output logic            sys_clk_tick,
    output logic            cpu_clk_tick,
    output logic            fast_clk_tick,
    output logic      [6:0] periph_div_tick,
    output logic            sub_clk_tick,
    output logic            cpu_halted,
    output scm_mode_type    op_mode
);
    if (FAST_SETTLE_CYCLES < 1 || FAST_SETTLE_CYCLES > 65535) begin : g_chk
        $error("scm_top: FAST_SETTLE_CYCLES out of range");
    end

    localparam logic [15:0] SETTLE_LOAD = 16'(FAST_SETTLE_CYCLES - 1);

    // Register and state storage
    logic [2:0]   sel_reg;
    logic         fidle_reg;
    logic         sidle_reg;
    logic [1:0]   fsel_reg;
    logic         fen_reg;
    logic         stable_reg;
    logic         stable_next;
    logic [15:0]  settle_reg;
    logic [15:0]  settle_next;
    scm_mode_type mode_reg;
    scm_mode_type mode_next;
    logic         fast_next;
    logic         sub_next;
    logic         slow_next;
    logic         sys_gate;

    // Selector and divider wires
    wire  [6:0]   div_tick;
    wire  [2:0]   active_sel;
    wire          switching;
    wire          mux_tick;

    function automatic logic is_sub(input logic [2:0] sel);
        is_sub = (sel == `SCM_SEL_SUB);
    endfunction

    // frequency code to oscillator trim, code 11 aliases to 8 MHz
    function automatic scm_freq_type freq_decode(input logic [1:0] code);
        unique case (code)
            2'b01:   freq_decode = FREQ_12M;
            2'b10:   freq_decode = FREQ_16M;
            default: freq_decode = FREQ_8M;
        endcase
    endfunction

    // Address decode
    wire wr_scc  = reg_wr && (reg_addr == `SCM_ADDR_SCC);
    wire wr_foc  = reg_wr && (reg_addr == `SCM_ADDR_FOC);
    wire [1:0] wr_fsel = reg_wdata[`SCM_FOC_FSEL_HI:`SCM_FOC_FSEL_LO];

    // Mode groupings
    wire running   = (mode_reg == MODE_FAST) || (mode_reg == MODE_SLOW);
    wire in_sleep  = (mode_reg == MODE_SLEEP);
    wire in_idle_sub_clock_only  = (mode_reg == MODE_IDLE_SUB_ONLY);
    wire in_idle_all_clocks_on  = (mode_reg == MODE_IDLE_ALL_ON);
    wire in_idle_fast_clock_only  = (mode_reg == MODE_IDLE_FAST_ONLY);
    wire fast_ok   = fast_rc_run && stable_reg;
    wire sub_ok    = sub_clk_run && slow_rc_run;
    // sub clock is the slow RC tick only
    wire sub_tick  = slow_rc_tick && sub_ok;
    wire run_mode_slow = is_sub(active_sel);
    wire tgt_ready = is_sub(sel_reg) ? sub_ok : fast_ok;

    // Control registers; software writes take effect on the next edge
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            // Reset fields are cut from the register reset words on purpose
            sel_reg   <= 3'(`SCM_SCC_RESET >> `SCM_SCC_SEL_LO);
            fidle_reg <= 1'(`SCM_SCC_RESET >> `SCM_SCC_FIDLE);
            sidle_reg <= 1'(`SCM_SCC_RESET >> `SCM_SCC_SIDLE);
            fsel_reg  <= 2'(`SCM_FOC_RESET >> `SCM_FOC_FSEL_LO);
            fen_reg   <= 1'(`SCM_FOC_RESET >> `SCM_FOC_EN);
        end else begin
            if (wr_scc) begin
                sel_reg   <= reg_wdata[`SCM_SCC_SEL_HI:`SCM_SCC_SEL_LO];
                fidle_reg <= reg_wdata[`SCM_SCC_FIDLE];
                sidle_reg <= reg_wdata[`SCM_SCC_SIDLE];
            end
            if (wr_foc) begin
                fsel_reg <= wr_fsel;
                fen_reg  <= reg_wdata[`SCM_FOC_EN];
            end
        end
    end

    // Operating mode sequencing on halt and wake
    always_comb begin
        mode_next = mode_reg;
        unique case (mode_reg)
            MODE_FAST, MODE_SLOW: begin
                if (halt_req) begin
                    unique case ({fidle_reg, sidle_reg})
                        2'b00: mode_next = MODE_SLEEP;
                        2'b01: mode_next = MODE_IDLE_SUB_ONLY;
                        2'b11: mode_next = MODE_IDLE_ALL_ON;
                        default: mode_next = MODE_IDLE_FAST_ONLY;
                    endcase
                end else begin
                    // run mode follows the live source
                    mode_next = run_mode_slow ? MODE_SLOW : MODE_FAST;
                end
            end
            MODE_SLEEP, MODE_IDLE_SUB_ONLY, MODE_IDLE_ALL_ON, MODE_IDLE_FAST_ONLY: begin
                if (wake_req) begin
                    mode_next = run_mode_slow ? MODE_SLOW : MODE_FAST;
                end
            end
            default: mode_next = MODE_FAST;
        endcase
    end

    // Oscillator run requests per mode
    always_comb begin
        // fast runs in fast mode, follows enable in slow mode while sub stays selected
        fast_next = (running && (fen_reg || !is_sub(sel_reg) || !is_sub(active_sel)))
                    || in_idle_all_clocks_on || in_idle_fast_clock_only;
        // sub clock kept only where its idle bit says
        sub_next  = running || in_idle_sub_clock_only || in_idle_all_clocks_on;
        // slow RC in sleep follows the watchdog
        slow_next = !in_sleep || wdt_enable;
    end

    // System clock gate: in idle the source must belong to a kept oscillator
    always_comb begin
        sys_gate = 1'b0;
        unique case (1'b1)
            running:  sys_gate = 1'b1;
            in_idle_sub_clock_only: sys_gate = run_mode_slow;
            in_idle_all_clocks_on: sys_gate = 1'b1;
            in_idle_fast_clock_only: sys_gate = !run_mode_slow;
            default:  sys_gate = 1'b0;
        endcase
    end

    // stable flag: restart settles on enable or frequency change
    wire fast_start  = fast_next && !fast_rc_run;
    wire fsel_change = wr_foc && (wr_fsel != fsel_reg);
    always_comb begin
        stable_next = stable_reg;
        settle_next = settle_reg;
        if (!fast_next) begin
            stable_next = 1'b0;
            settle_next = SETTLE_LOAD;
        end else if (fast_start || fsel_change) begin
            stable_next = 1'b0;
            settle_next = SETTLE_LOAD;
        end else if (!stable_reg) begin
            if (settle_reg == 16'h0000) begin
                stable_next = 1'b1;
            end else begin
                settle_next = settle_reg - 16'h0001;
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stable_reg <= 1'b0;
            settle_reg <= SETTLE_LOAD;
            mode_reg   <= MODE_FAST;
        end else begin
            stable_reg <= stable_next;
            settle_reg <= settle_next;
            mode_reg   <= mode_next;
        end
    end

    // Divided fast ticks; blocked until the oscillator has settled
    scm_clk_div #(
        .N_TAPS (7)
    ) u_div (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .fast_tick (fast_rc_tick),
        .fast_ok   (fast_ok),
        .div_tick  (div_tick)
    );

    scm_clk_sel u_sel (
        .core_clk   (core_clk),
        .sys_rst    (sys_rst),
        .src_tick   ({sub_tick, div_tick}),
        .tgt_sel    (sel_reg),
        .tgt_ready  (tgt_ready),
        .active_sel (active_sel),
        .switching  (switching),
        .sys_tick   (mux_tick)
    );

    // Registered outputs toward oscillators and clock consumers
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            fast_rc_run     <= 1'b0;
            fast_rc_trim    <= FREQ_8M;
            slow_rc_run     <= 1'b1;
            sub_clk_run     <= 1'b1;
            sys_clk_tick    <= 1'b0;
            cpu_clk_tick    <= 1'b0;
            fast_clk_tick   <= 1'b0;
            periph_div_tick <= 7'h00;
            sub_clk_tick    <= 1'b0;
            cpu_halted      <= 1'b0;
            op_mode         <= MODE_FAST;
        end else begin
            fast_rc_run     <= fast_next;
            // trim follows the field; consumers wait for the flag
            fast_rc_trim    <= freq_decode(fsel_reg);
            slow_rc_run     <= slow_next;
            sub_clk_run     <= sub_next;
            sys_clk_tick    <= mux_tick && sys_gate;
            cpu_clk_tick    <= mux_tick && running;
            // peripherals keep the fast clock while it runs
            fast_clk_tick   <= div_tick[0];
            periph_div_tick <= div_tick;
            sub_clk_tick    <= sub_tick;
            cpu_halted      <= !running;
            op_mode         <= mode_reg;
        end
    end

    // Read mux; unmapped addresses read zero
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        unique case (reg_addr)
            // bits 4 to 2 read zero
            `SCM_ADDR_SCC: begin
                rd_mux[`SCM_SCC_SEL_HI:`SCM_SCC_SEL_LO] = sel_reg;
                rd_mux[`SCM_SCC_FIDLE] = fidle_reg;
                rd_mux[`SCM_SCC_SIDLE] = sidle_reg;
            end
            `SCM_ADDR_FOC: begin
                rd_mux[`SCM_FOC_FSEL_HI:`SCM_FOC_FSEL_LO] = fsel_reg;
                rd_mux[`SCM_FOC_STABLE] = stable_reg;
                rd_mux[`SCM_FOC_EN] = fen_reg;
            end
            // Live source and switch-in-progress, so software can time its delay
            `SCM_ADDR_STAT: rd_mux = {active_sel, switching, 1'b0, mode_reg};
            default: rd_mux = 8'h00;
        endcase
    end

    // Read data stands in the cycle after the strobe only
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
        end
    end
endmodule

// ### scm_osc_model.sv
`timescale 1ns/1ps
// Oscillator stand-in: tick pulses only while the block keeps each one running
module scm_osc_model
    import scm_pkg::*;
(
    input  wire logic         core_clk,
    input  wire logic         sys_rst,
    input  wire logic         fast_rc_run,
    input  wire scm_freq_type fast_rc_trim,
    input  wire logic         slow_rc_run,
    output logic              fast_rc_tick,
    output logic              slow_rc_tick
);
    int fc;
    int sc;
    int fp;
    // Period follows the trim code, 11 never reaches the oscillator
    assign fp = (fast_rc_trim == FREQ_16M) ? 3 : (fast_rc_trim == FREQ_12M) ? 4 : 6;
    // Slow counter runs on when stopped; its tick is gated by slow_rc_run, so a stale tick cannot leak out
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            fc <= 0;
            sc <= 0;
            fast_rc_tick <= 1'b0;
            slow_rc_tick <= 1'b0;
        end else begin
            fc <= (fc >= fp - 1) ? 0 : fc + 1;
            sc <= (sc >= 15) ? 0 : sc + 1;
            fast_rc_tick <= fast_rc_run && fc == 0;
            slow_rc_tick <= slow_rc_run && sc == 0;
        end
    end
endmodule

// ### scm_top_chk.sv
`timescale 1ns/1ps
// Mode and gating relations seen at the controller's pins
module scm_top_chk
    import scm_pkg::*;
(
    input  wire logic         core_clk,
    input  wire logic         sys_rst,
    input  wire logic [7:0]   reg_addr,
    input  wire logic         reg_rd,
    input  wire logic [7:0]   reg_rdata,
    input  wire logic         halt_req,
    input  wire logic         wdt_enable,
    input  wire logic         fast_rc_run,
    input  wire scm_freq_type fast_rc_trim,
    input  wire logic         slow_rc_run,
    input  wire logic         sub_clk_run,
    input  wire logic         sys_clk_tick,
    input  wire logic         cpu_clk_tick,
    input  wire logic         cpu_halted,
    input  wire scm_mode_type op_mode
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // Assertions on read data, trim code and each operating mode
    scc_zero_a: assert property ($past(reg_rd && reg_addr == 8'h00) |-> reg_rdata[4:2] == 3'b000)
        else $error("select register reserved bits not zero");
    trim_code_a: assert property (fast_rc_trim != 2'b11)
        else $error("trim code 11 sent to oscillator");
    fast_on_a: assert property (op_mode == MODE_FAST && !$past(sys_rst) |-> fast_rc_run && sub_clk_run && slow_rc_run)
        else $error("clock stopped in fast mode");
    slow_sub_a: assert property (op_mode == MODE_SLOW |-> sub_clk_run && slow_rc_run && !cpu_halted)
        else $error("sub clock off in slow mode");
    sleep_stop_a: assert property (op_mode == MODE_SLEEP |-> !fast_rc_run && !sub_clk_run && !sys_clk_tick)
        else $error("clock running in sleep");
    sleep_wdt_a: assert property (op_mode == MODE_SLEEP && $stable(wdt_enable) |-> slow_rc_run == wdt_enable)
        else $error("slow rc does not follow watchdog in sleep");
    idle_sub_a: assert property (op_mode == MODE_IDLE_SUB_ONLY |-> !fast_rc_run && sub_clk_run)
        else $error("wrong clocks in sub only idle");
    idle_all_a: assert property (op_mode == MODE_IDLE_ALL_ON |-> fast_rc_run && sub_clk_run && slow_rc_run)
        else $error("clock stopped in all on idle");
    idle_fast_a: assert property (op_mode == MODE_IDLE_FAST_ONLY |-> fast_rc_run && !sub_clk_run)
        else $error("wrong clocks in fast only idle");
    halt_cause_a: assert property ($rose(cpu_halted) |-> $past(halt_req, 2))
        else $error("halted without halt request");
    cpu_gate_a: assert property (cpu_halted |-> !cpu_clk_tick)
        else $error("cpu tick while halted");
    tick_clean_a: assert property (sys_clk_tick |=> !sys_clk_tick)
        else $error("system tick doubled");
    // Main scenarios reached
    cover property (op_mode == MODE_SLEEP);
    cover property (op_mode == MODE_IDLE_ALL_ON);
    cover property (op_mode == MODE_SLOW);
endmodule

bind scm_top scm_top_chk u_chk (.core_clk, .sys_rst, .reg_addr, .reg_rd, .reg_rdata, .halt_req, .wdt_enable,
    .fast_rc_run, .fast_rc_trim, .slow_rc_run, .sub_clk_run, .sys_clk_tick, .cpu_clk_tick, .cpu_halted, .op_mode);

// ### system_clock_mode_control_tb.sv
`timescale 1ns/1ps
module system_clock_mode_control_tb;
    import scm_pkg::*;
    logic         core_clk = 1'b0;
    logic         sys_rst = 1'b1;
    logic [7:0]   reg_addr = 8'h00;
    logic [7:0]   reg_wdata = 8'h00;
    logic         reg_wr = 1'b0;
    logic         reg_rd = 1'b0;
    logic         halt_req = 1'b0;
    logic         wake_req = 1'b0;
    logic         wdt_enable = 1'b0;
    logic [7:0]   reg_rdata;
    logic         fast_rc_tick;
    logic         slow_rc_tick;
    logic         fast_rc_run;
    logic         slow_rc_run;
    logic         sub_clk_run;
    logic         sys_clk_tick;
    logic         cpu_clk_tick;
    logic         fast_clk_tick;
    logic         sub_clk_tick;
    logic [6:0]   periph_div_tick;
    logic         cpu_halted;
    scm_freq_type fast_rc_trim;
    scm_mode_type op_mode;
    int           n_mismatch = 0;
    int           checks_done = 0;
    int           cyc = 0;
    int           scc_m;
    int           foc_m;
    int           ns;
    int           nf;
    int           nb;
    int           np;
    int           ex;
    logic [7:0]   d;
    logic [7:0]   em;
    logic [31:0]  r;

    always #2 core_clk = ~core_clk;

    scm_top #(.FAST_SETTLE_CYCLES(4)) dut_u (.core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .halt_req, .wake_req, .wdt_enable, .fast_rc_tick, .slow_rc_tick, .fast_rc_run,
        .fast_rc_trim, .slow_rc_run, .sub_clk_run, .sys_clk_tick, .cpu_clk_tick, .fast_clk_tick,
        .periph_div_tick, .sub_clk_tick, .cpu_halted, .op_mode);

    scm_osc_model osc_u (.core_clk, .sys_rst, .fast_rc_run, .fast_rc_trim, .slow_rc_run, .fast_rc_tick,
        .slow_rc_tick);

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Register bus master: one strobe cycle, read data taken in the following cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    // Polls status until the selector has settled on the wanted source
    task automatic wait_sw(input logic [2:0] s);
        for (int i = 0; i < 300; i++) begin
            rd(8'h02, d);
            if (d[4] === 1'b0 && d[7:5] === s) break;
        end
        check("active select", {5'h00, d[7:5]}, {5'h00, s});
    endtask

    task automatic count(input int n);
        ns = 0;
        nf = 0;
        nb = 0;
        np = 0;
        repeat (n) begin
            @(posedge core_clk);
            #1;
            ns += sys_clk_tick;
            nf += fast_clk_tick;
            nb += sub_clk_tick;
            np += periph_div_tick[6];
        end
    endtask

    task automatic pulse_halt(input logic w);
        @(posedge core_clk);
        if (w) begin
            wake_req <= 1'b1;
        end else begin
            halt_req <= 1'b1;
        end
        @(posedge core_clk);
        wake_req <= 1'b0;
        halt_req <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
    endtask

    // Hang guard
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 60000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    initial begin
        r = $urandom(32'h27b2_048d);
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (12) @(posedge core_clk);
        rd(8'h01, d);
        check("fast ctrl reset", d, 8'h03);
        rd(8'h00, d);
        check("select reset", d, 8'h00);
        rd(8'h05, d);
        check("unmapped read", d, 8'h00);
        // Every frequency code in order 01, 10, 11, 00, so each write is a real change
        for (int i = 0; i < 4; i++) begin
            foc_m = ((i + 1) % 4) * 4 + 1;
            // software returns the code to the factory setting last
            wr(8'h01, 8'(foc_m));
            rd(8'h01, d);
            check("flag cleared", d, 8'(foc_m));
            repeat (12) @(posedge core_clk);
            rd(8'h01, d);
            check("flag set", d, 8'(foc_m | 2));
            check("trim", {6'h00, fast_rc_trim}, (foc_m >> 2) == 3 ? 8'h00 : 8'(foc_m >> 2));
        end
        r = $urandom;
        scc_m = r[4:0];
        wr(8'h00, 8'(scc_m));
        rd(8'h00, d);
        check("select readback", d, 8'(scc_m & 3));
        // Every select code: tick ratio against the fast and sub clocks
        for (int s = 0; s < 8; s++) begin
            wr(8'h00, 8'(s << 5));
            // no dependence on the new source until it is live
            wait_sw(3'(s));
            count(2048);
            // Counts run past 255, so the expectation is kept as a full integer
            ex = (s == 7) ? nb : nf >> s;
            check("sys ratio", 8'(ns >= ex - 1 && ns <= ex + 1), 8'h01);
            check("periph div64", 8'(np >= (nf >> 6) - 1 && np <= (nf >> 6) + 1), 8'h01);
        end
        // In slow mode the fast oscillator follows its enable
        wr(8'h01, 8'h00);
        repeat (4) @(posedge core_clk);
        #1;
        check("fast off", {7'h00, fast_rc_run}, 8'h00);
        wr(8'h01, 8'h01);
        repeat (4) @(posedge core_clk);
        #1;
        check("fast on", {7'h00, fast_rc_run}, 8'h01);
        // Halt table over idle enables and both source kinds
        for (int k = 0; k < 8; k++) begin
            scc_m = {k[2] ? 3'h7 : 3'h0, 3'h0, k[1:0]};
            r = $urandom;
            wdt_enable <= r[0];
            wr(8'h00, 8'(scc_m));
            wait_sw(scc_m[7:5]);
            pulse_halt(1'b0);
            em = (k[1:0] == 0) ? 8'(MODE_SLEEP) : (k[1:0] == 1) ? 8'(MODE_IDLE_SUB_ONLY) :
                 (k[1:0] == 3) ? 8'(MODE_IDLE_ALL_ON) : 8'(MODE_IDLE_FAST_ONLY);
            check("halt mode", 8'(op_mode), em);
            count(800);
            em = 8'((k[1:0] == 3) || (k[1:0] == 1 && k[2]) || (k[1:0] == 2 && !k[2]));
            check("idle sys clock", 8'(ns > 0), em);
            if (k[1:0] == 0) begin
                check("sleep slow rc", {7'h00, slow_rc_run}, {7'h00, r[0]});
            end
            pulse_halt(1'b1);
            check("wake mode", 8'(op_mode), k[2] ? 8'(MODE_SLOW) : 8'(MODE_FAST));
        end
        report_and_stop();
    end
endmodule
